// file: fs_limp_home.sv
`timescale 1ns/1ps
`default_nettype none
module fs_limp_home #(
  parameter int unsigned LIMP_DELAY_NS  = 100000,
  parameter int unsigned LIMP_DELAY_CYC =
    (LIMP_DELAY_NS + fs_pkg::CLK_PERIOD_NS - 1) / fs_pkg::CLK_PERIOD_NS
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic reset_mode,
  input  wire logic forced_normal_config,
  input  wire logic overtemp,
  input  wire logic spi_sck,
  input  wire logic spi_csn,
  input  wire logic spi_mosi,
  output logic      spi_miso,
  output logic      spi_miso_oe,
  output logic      limp_out,
  output logic      limp_oe
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  localparam logic [fs_pkg::TMR_W-1:0] DELAY = fs_pkg::TMR_W'(LIMP_DELAY_CYC);

  function automatic logic [fs_pkg::TMR_W-1:0] tmr_next(
    input logic                      cond,
    input logic [fs_pkg::TMR_W-1:0] cnt
  );
    if (!cond) begin
      tmr_next = '0;
    end else if (cnt == DELAY) begin
      tmr_next = cnt;
    end else begin
      tmr_next = cnt + fs_pkg::TMR_W'(1);
    end
  endfunction : tmr_next

  // ----------------------------------------
  // register access
  // ----------------------------------------
  fs_pkg::fs_spi_req_type req;
  logic                   force_q;
  logic [1:0]             evt_cnt_q;

  wire logic       fsc_hit = (req.addr == fs_pkg::FSC_ADDR);
  wire logic       wr_fsc  = req.wr & fsc_hit;
  wire logic [7:0] rdata   = fsc_hit ? {fs_pkg::FSC_RSVD, force_q, evt_cnt_q} : fs_pkg::RDATA_UNMAP;

  fs_spi_slave u_spi (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .spi_sck     (spi_sck),
    .spi_csn     (spi_csn),
    .spi_mosi    (spi_mosi),
    .rdata       (rdata),
    .req         (req),
    .spi_miso    (spi_miso),
    .spi_miso_oe (spi_miso_oe)
  );

  // ----------------------------------------
  // overtemperature synchroniser
  // ----------------------------------------
  logic ot_meta_q;
  logic ot_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ot_meta_q <= 1'h0;
      ot_q      <= 1'h0;
    end else begin
      ot_meta_q <= overtemp;
      ot_q      <= ot_meta_q;
    end
  end

  // ----------------------------------------
  // delay timers
  // ----------------------------------------
  logic [fs_pkg::TMR_W-1:0] ot_cnt_q;
  logic [fs_pkg::TMR_W-1:0] dw_cnt_q;
  logic                     rst_mode_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ot_cnt_q   <= '0;
      dw_cnt_q   <= '0;
      rst_mode_q <= 1'h0;
    end else begin
      ot_cnt_q   <= tmr_next(ot_q, ot_cnt_q);
      dw_cnt_q   <= tmr_next(reset_mode, dw_cnt_q);
      rst_mode_q <= reset_mode;
    end
  end

  // saturating at the delay keeps the trigger a level, so a clear write cannot win
  // overtemperature and reset dwell expiry
  wire logic ot_exp   = ot_q & (ot_cnt_q == DELAY);
  wire logic dw_exp   = reset_mode & (dw_cnt_q == DELAY);

  // ----------------------------------------
  // fail-safe control
  // ----------------------------------------
  wire logic fnm      = forced_normal_config;
  wire logic entry    = reset_mode & ~rst_mode_q & ~fnm;
  wire logic overflow  = entry & (evt_cnt_q == fs_pkg::CNT_MAX);
  wire logic set_force = ~fnm & (overflow | ot_exp | dw_exp);

  wire logic       wr_force = req.wdata[fs_pkg::FORCE_BIT];
  wire logic [1:0] wr_cnt   = req.wdata[fs_pkg::CNT_MSB:fs_pkg::CNT_LSB];

  wire logic       force_d   = fnm       ? 1'h0 :
                               set_force ? 1'h1 :
                               wr_fsc    ? wr_force : force_q;
  wire logic [1:0] evt_cnt_d = entry     ? evt_cnt_q + fs_pkg::CNT_ONE :
                               wr_fsc    ? wr_cnt : evt_cnt_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      force_q   <= fs_pkg::FORCE_RESET;
      evt_cnt_q <= fs_pkg::CNT_RESET;
      limp_out  <= 1'h0;
      limp_oe   <= 1'h0;
    end else begin
      force_q   <= force_d;
      evt_cnt_q <= evt_cnt_d;
      limp_out  <= 1'h0;
      limp_oe   <= force_d;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence seq_entry_at_max;
    entry && (evt_cnt_q == fs_pkg::CNT_MAX);
  endsequence

  sequence seq_limp_wrapped;
    force_q && limp_oe && (evt_cnt_q == fs_pkg::CNT_RESET);
  endsequence

  property p_overflow;
    @(posedge sys_clk) disable iff (!reset_n)
    seq_entry_at_max |=> seq_limp_wrapped;
  endproperty

  a_overflow_sets_limp: assert property (p_overflow)
    else $error("overflow did not set limp or wrap counter");

  a_entry_counts_up: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    entry |=> evt_cnt_q == $past(evt_cnt_q) + fs_pkg::CNT_ONE)
    else $error("reset entry did not increment counter");

  a_pin_follows_bit: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (limp_oe == force_q) && !limp_out)
    else $error("limp pin disagrees with force bit");

  a_fnm_disables_limp: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    fnm && !wr_fsc |=> !force_q && !limp_oe && $stable(evt_cnt_q))
    else $error("forced normal did not disable limp");

  a_sw_sets_bit: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    wr_fsc && wr_force && !fnm |=> force_q ##1 limp_oe)
    else $error("software set of force bit lost");

  a_bit_sticks: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    force_q && !fnm && !(wr_fsc && !wr_force) |=> force_q)
    else $error("force bit cleared without software");

  a_sw_writes_count: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    wr_fsc && !entry |=> evt_cnt_q == $past(wr_cnt))
    else $error("counter write not taken");

  a_ot_sets_limp: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    ot_exp && !fnm |=> force_q)
    else $error("overtemperature expiry did not set limp");

  a_dwell_sets_limp: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    dw_exp && !fnm |=> force_q)
    else $error("reset dwell expiry did not set limp");

  a_timer_clears: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (!ot_q |=> ot_cnt_q == '0) and (!reset_mode |=> dw_cnt_q == '0))
    else $error("delay timer not cleared when cause ended");

  a_timer_counts: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    reset_mode && (dw_cnt_q < DELAY) |=> dw_cnt_q == $past(dw_cnt_q) + fs_pkg::TMR_W'(1))
    else $error("dwell timer did not advance");

endmodule : fs_limp_home
`default_nettype wire

// file: fs_limp_load.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// external limp-home load
// ----------------------------------------
module fs_limp_load (
  input  wire logic limp_out,
  input  wire logic limp_oe,
  output logic      limp_pin
);
  // pull-up wins whenever the open-drain driver lets go
  assign limp_pin = limp_oe ? limp_out : 1'b1;
endmodule : fs_limp_load
`default_nettype wire

// file: fs_pkg.sv
package fs_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [6:0] FSC_ADDR      = 7'h02;
  localparam int         FORCE_BIT     = 2;
  localparam int         CNT_LSB       = 0;
  localparam int         CNT_MSB       = 1;
  localparam logic [1:0] CNT_RESET     = 2'h0;
  localparam logic [1:0] CNT_MAX       = 2'h3;
  localparam logic [1:0] CNT_ONE       = 2'h1;
  localparam logic       FORCE_RESET   = 1'h0;
  localparam logic [4:0] FSC_RSVD      = 5'h00;
  localparam logic [7:0] RDATA_UNMAP   = 8'h00;

  // ----------------------------------------
  // serial frame
  // ----------------------------------------
  localparam logic [3:0] BIT_LAST_HDR  = 4'h7;
  localparam logic [3:0] BIT_FIRST_DAT = 4'h8;
  localparam logic [3:0] BIT_LAST_DAT  = 4'hf;
  localparam logic [3:0] BIT_ONE       = 4'h1;
  localparam logic [3:0] BIT_ZERO      = 4'h0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int         CLK_PERIOD_NS = 20;
  localparam int         TMR_W         = 20;

  typedef enum logic [1:0] {
    FS_SPI_IDLE = 2'h0,
    FS_SPI_HDR  = 2'h1,
    FS_SPI_DAT  = 2'h3,
    FS_SPI_DONE = 2'h2
  } fs_spi_state_type;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       wr;
  } fs_spi_req_type;

endpackage : fs_pkg

// file: fs_spi_slave.sv
`timescale 1ns/1ps
`default_nettype none
module fs_spi_slave (
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              spi_sck,
  input  wire logic              spi_csn,
  input  wire logic              spi_mosi,
  input  wire logic [7:0]        rdata,
  output fs_pkg::fs_spi_req_type req,
  output logic                   spi_miso,
  output logic                   spi_miso_oe
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic       sck_prev_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q     <= 3'h1;
      sync_q     <= 3'h1;
      sck_prev_q <= 1'h0;
    end else begin
      meta_q     <= {spi_sck, spi_mosi, spi_csn};
      sync_q     <= meta_q;
      sck_prev_q <= sync_q[2];
    end
  end

  wire logic cs_act = ~sync_q[0];
  wire logic mosi   = sync_q[1];
  wire logic rise   = sync_q[2] & ~sck_prev_q;
  wire logic fall   = ~sync_q[2] & sck_prev_q;

  // ----------------------------------------
  // frame engine
  // ----------------------------------------
  // sck is oversampled, so it must stay well below a quarter of sys_clk
  fs_pkg::fs_spi_state_type state_q;
  logic [3:0]               cnt_q;
  logic [7:0]               sh_q;
  logic [7:0]               tx_q;
  logic                     ro_q;

  wire logic [7:0] sh_d = {sh_q[6:0], mosi};

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= fs_pkg::FS_SPI_IDLE;
      cnt_q       <= fs_pkg::BIT_ZERO;
      sh_q        <= 8'h00;
      tx_q        <= 8'h00;
      ro_q        <= 1'h1;
      req         <= '0;
      spi_miso    <= 1'h0;
      spi_miso_oe <= 1'h0;
    end else begin
      req.wr      <= 1'h0;
      spi_miso_oe <= cs_act;
      if (!cs_act) begin
        state_q <= fs_pkg::FS_SPI_IDLE;
        cnt_q   <= fs_pkg::BIT_ZERO;
      end else begin
        case (state_q)
          fs_pkg::FS_SPI_IDLE: begin
            state_q <= fs_pkg::FS_SPI_HDR;
          end
          fs_pkg::FS_SPI_HDR: begin
            if (rise) begin
              sh_q  <= sh_d;
              cnt_q <= cnt_q + fs_pkg::BIT_ONE;
              if (cnt_q == fs_pkg::BIT_LAST_HDR) begin
                req.addr <= sh_q[6:0];
                ro_q     <= mosi;
                state_q  <= fs_pkg::FS_SPI_DAT;
              end
            end
          end
          fs_pkg::FS_SPI_DAT: begin
            if (fall) begin
              if (cnt_q == fs_pkg::BIT_FIRST_DAT) begin
                spi_miso <= rdata[7];
                tx_q     <= {rdata[6:0], 1'h0};
              end else begin
                spi_miso <= tx_q[7];
                tx_q     <= {tx_q[6:0], 1'h0};
              end
            end
            if (rise) begin
              sh_q  <= sh_d;
              cnt_q <= cnt_q + fs_pkg::BIT_ONE;
              if (cnt_q == fs_pkg::BIT_LAST_DAT) begin
                req.wdata <= sh_d;
                req.wr    <= ~ro_q;
                state_q   <= fs_pkg::FS_SPI_DONE;
              end
            end
          end
          fs_pkg::FS_SPI_DONE: begin
            state_q <= fs_pkg::FS_SPI_DONE;
          end
          default: begin
            state_q <= fs_pkg::FS_SPI_IDLE;
          end
        endcase
      end
    end
  end

endmodule : fs_spi_slave
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       sys_clk              = 1'b0;
  logic       reset_n              = 1'b0;
  logic       reset_mode           = 1'b0;
  logic       forced_normal_config = 1'b0;
  logic       overtemp             = 1'b0;
  logic       sck                  = 1'b0;
  logic       csn                  = 1'b1;
  logic       mosi                 = 1'b0;
  wire logic  miso;
  wire logic  miso_oe;
  wire logic  limp_out;
  wire logic  limp_oe;
  wire logic  limp_pin;
  int         error_cnt            = 0;
  int         tests_run            = 0;
  int         evt_cnt              = 0;
  int         force_bit            = 0;
  logic [7:0] rd;
  logic       oe_mid;

  // short delay keeps timer tests brief; frame length sets the watchdog span
  localparam int LIMP_CYC  = 10;
  localparam int FRAME_CYC = 12 + 16 * 12 + 8;
  localparam int WDOG_CYC  = 100 * FRAME_CYC;

  fs_limp_home #(.LIMP_DELAY_CYC(LIMP_CYC)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .reset_mode(reset_mode),
    .forced_normal_config(forced_normal_config), .overtemp(overtemp),
    .spi_sck(sck), .spi_csn(csn), .spi_mosi(mosi), .spi_miso(miso),
    .spi_miso_oe(miso_oe), .limp_out(limp_out), .limp_oe(limp_oe)
  );
  fs_limp_load load (.limp_out(limp_out), .limp_oe(limp_oe), .limp_pin(limp_pin));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // six-cycle phases keep sck well under sys_clk/8
  task automatic xfer(input logic [6:0] addr, input logic rnw, input logic [7:0] wd);
    logic [15:0] sh;
    sh = {addr, rnw, wd};
    csn <= 1'b0;
    tick(6);
    for (int i = 15; i >= 0; i--) begin
      mosi <= sh[i];
      tick(6);
      sck <= 1'b1;
      tick(6);
      if (i < 8) rd[i] = miso;
      if (i == 0) oe_mid = miso_oe;
      sck <= 1'b0;
    end
    tick(6);
    csn <= 1'b1;
    tick(8);
  endtask : xfer

  task automatic rd_chk(input string name);
    logic [7:0] e;
    e = {5'h00, force_bit[0] & ~forced_normal_config, evt_cnt[1:0]};
    xfer(fs_pkg::FSC_ADDR, 1'b1, 8'h00);
    check(name, rd, e);
    check("limp pin", {7'h00, limp_pin}, {7'h00, ~e[2]});
    check("miso enable in frame", {7'h00, oe_mid}, 8'h01);
    check("miso enable idle", {7'h00, miso_oe}, 8'h00);
  endtask : rd_chk

  task automatic wr(input logic [7:0] d);
    xfer(fs_pkg::FSC_ADDR, 1'b0, d);
    evt_cnt = d[1:0];
    force_bit = forced_normal_config ? 0 : d[2];
  endtask : wr

  // dwell of more than LIMP_CYC cycles also trips the delay timer
  task automatic enter_reset(input int n);
    reset_mode <= 1'b1;
    tick(n);
    reset_mode <= 1'b0;
    tick(2);
    if (!forced_normal_config) begin
      if (evt_cnt == 3) force_bit = 1;
      evt_cnt = (evt_cnt + 1) % 4;
      if (n > LIMP_CYC) force_bit = 1;
    end
  endtask : enter_reset

  task automatic overheat(input int n);
    overtemp <= 1'b1;
    tick(n);
    overtemp <= 1'b0;
    tick(4);
    if (n > LIMP_CYC && !forced_normal_config) force_bit = 1;
  endtask : overheat

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    tick(WDOG_CYC);
    error_cnt++;
    $display("unexpected watchdog expected done seen hang");
    end_sim();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(84));
    tick(3);
    reset_n <= 1'b1;
    tick(4);
    rd_chk("power-up value");
    $display("test power-up done");
    for (int k = 0; k < 4; k++) begin
      enter_reset(2);
      rd_chk("reset entry count");
    end
    $display("test reset entries done");
    wr(8'h00);
    rd_chk("software clear");
    wr(8'h04);
    rd_chk("software set");
    repeat (6) begin
      wr(8'($urandom()));
      rd_chk("random write");
    end
    wr(8'h03);
    enter_reset(2);
    rd_chk("preset wrap");
    $display("test software access done");
    xfer(7'h05, 1'b0, 8'hff);
    xfer(7'h05, 1'b1, 8'h00);
    check("unmapped read", rd, fs_pkg::RDATA_UNMAP);
    rd_chk("after unmapped write");
    $display("test unmapped done");
    wr(8'h00);
    overheat(LIMP_CYC);
    rd_chk("short overtemp");
    overheat(LIMP_CYC + 1);
    rd_chk("long overtemp");
    wr(8'h01);
    enter_reset(LIMP_CYC + 1);
    rd_chk("reset dwell");
    $display("test delay timers done");
    forced_normal_config <= 1'b1;
    force_bit = 0;
    tick(2);
    rd_chk("forced normal");
    enter_reset(20);
    overheat(20);
    wr(8'h06);
    rd_chk("forced normal hold");
    forced_normal_config <= 1'b0;
    tick(2);
    rd_chk("forced normal exit");
    $display("test forced normal done");
    wr(8'h07);
    reset_n <= 1'h0;
    tick(3);
    reset_n <= 1'h1;
    evt_cnt = 0;
    force_bit = 0;
    tick(4);
    rd_chk("power-up clear");
    $display("test mid-run reset done");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
